/* src/sstm_monitor.sv */
/*
  Second screw tracking monitor: per control pass it checks the second
  screw sensor against focus position, stops the drive on tracking faults
  and reports through APB registers and one interrupt.
  Assumes inputs synchronous to clk_in and a position word stable at passes.
*/
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Tracking fault shuts focus drive down immediately
// - Per-state count must not exceed 50
// - Fault sets fault bits and second chance
// - Repeat failure with second chance refuses commands
// - Second chance cleared only by reset
// - Phase register holds previous sensor level
// - Keep last pass position within current state
// - Delta is position minus saved; keep previous
// - Flag large changes and count them
// - Ignore flag skips straight to filter evaluation; here it skips all analysis and the filter flag holds
// - Sensor bit taken by masking with 32
// - Transition found by XOR, either edge
// - Store new sample into phase after compare
// - Control pass runs at 1800 Hz
// - Transition zeroes count, no further action
// - Delta beyond plus/minus 12 sets flag
// - Ten excessive changes: fault bits, shutdown
module sstm_monitor #(
  parameter int PASS_PERIOD = sstm_pkg::PASS_CYCLES  // Cycles per control pass
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] discretes_in,            // Discretes byte with sensor bit
  input wire logic [15:0] focus_position_now_in,  // Focus position readout
  output logic drive_shutdown_out,                // High: focus drive must stop
  output logic focus_cmd_refuse_out,              // High: focus commands refused
  output logic pass_strobe_out,                   // One-cycle pulse per pass
  output logic irq_out                            // Level interrupt
);
  // Pass strobe from the period timer
  // A soft reset restarts the timer, so the next pass comes a full period later
  logic pass_w;
  logic soft_reset_w;

  sstm_pass_timer #(
    .PERIOD(PASS_PERIOD)
  ) u_timer (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .restart_in(soft_reset_w),
    .pass_out(pass_w)
  );

  // Tracking state
  // Hardware reset and soft reset both return all of it to zero
  logic sensor_phase_last_q;            // Previous masked sensor sample
  logic signed [15:0] state_motion_count_q;  // Accumulated motion in state
  logic [15:0] state_position_saved_q;  // Position of previous pass in state
  logic signed [15:0] delta_old_q;      // Previous accepted delta
  logic excess_change_flag_q;           // Large per-pass change seen
  logic [3:0] excess_change_counter_q;  // Number of large changes
  logic second_chance_flag_q;           // Sticky after first tracking fault
  logic [15:0] fault_word_q;            // Fault indication bits
  logic shutdown_q;                     // Drive shutdown level
  logic refuse_q;                       // Focus command refusal level

  // Software registers
  // The event width is declared first because the status and mask
  // registers below take their width from it
  localparam int EV_W = sstm_pkg::EV_WIDTH;  // Number of interrupt events
  logic screw_check_ignore_q;           // Skip tracking analysis
  logic [EV_W-1:0] irq_stat_q;          // Sticky events
  logic [EV_W-1:0] irq_mask_q;          // Event enables

  // APB handshake: one wait state, answer registered
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // Sensor sample and transition decode
  wire [7:0] sample_byte_w = discretes_in & sstm_pkg::SENSOR_MASK;
  wire sample_w = |sample_byte_w;
  wire transition_w = sample_w ^ sensor_phase_last_q;

  // Local delta against saved position
  // Positions wrap at 16 bits, so the difference is read as signed;
  // moving up gives a positive delta and moving down a negative one
  wire signed [15:0] delta_new_w =
    $signed(focus_position_now_in - state_position_saved_q);
  wire delta_big_w = (delta_new_w > sstm_pkg::DELTA_LIMIT) ||
                     (delta_new_w < -sstm_pkg::DELTA_LIMIT);
  wire [3:0] excess_next_w = excess_change_counter_q + 4'h1;
  wire excess_full_w = (excess_change_counter_q == sstm_pkg::EXCESS_MAX);  // Held at limit
  wire excess_trip_w = delta_big_w && (excess_next_w == sstm_pkg::EXCESS_MAX);

  // Accumulate accepted delta, substituting the old one when excessive
  // The sum is checked before it is stored, so a fault is caught on the
  // very pass that carries the count past tolerance
  wire signed [15:0] accepted_w = delta_big_w ? delta_old_q : delta_new_w;
  wire signed [15:0] count_sum_w = state_motion_count_q + accepted_w;
  wire count_over_w = (count_sum_w > sstm_pkg::TRACK_TOL) ||
                      (count_sum_w < -sstm_pkg::TRACK_TOL);

  // Qualified pass events; while ignore is set nothing is analysed and no
  // state moves, so the filter flag simply keeps its last value
  wire analyse_w = pass_w && !screw_check_ignore_q;
  wire steady_w = analyse_w && !transition_w;
  wire trip_excess_w = steady_w && excess_trip_w;
  // A stopped drive cannot fail again: while the shutdown stands, a count
  // left above tolerance must not trip again and turn one fault into a
  // refusal on the following pass
  wire trip_screw_w = steady_w && !excess_trip_w && count_over_w && !shutdown_q;
  wire set_flag_w = steady_w && delta_big_w;

  // APB decode
  // A write takes effect only at the edge where pready is sampled high
  wire access_w = psel && penable;
  wire done_w = access_w && pready_q;
  wire wr_w = done_w && pwrite;
  wire hit_ctrl_w = (paddr == sstm_pkg::ADDR_CTRL);
  wire hit_fault_w = (paddr == sstm_pkg::ADDR_FAULT);
  wire hit_state_w = (paddr == sstm_pkg::ADDR_STATE);
  wire hit_stat_w = (paddr == sstm_pkg::ADDR_IRQ_STAT);
  wire hit_mask_w = (paddr == sstm_pkg::ADDR_IRQ_MASK);
  wire hit_pos_w = (paddr == sstm_pkg::ADDR_POS);
  wire mapped_w = hit_ctrl_w | hit_fault_w | hit_state_w | hit_stat_w |
                  hit_mask_w | hit_pos_w;
  wire wr_ctrl_w = wr_w && hit_ctrl_w;
  assign soft_reset_w = wr_ctrl_w && pwdata[sstm_pkg::CTRL_SOFTRST_BIT];
  wire restart_w = wr_ctrl_w && pwdata[sstm_pkg::CTRL_RESTART_BIT];

  // Read data selection
  // Unmapped addresses read as zero alongside the error response
  wire [31:0] state_word_w = {7'h00,
                              sensor_phase_last_q,
                              refuse_q,
                              shutdown_q,
                              second_chance_flag_q,
                              excess_change_flag_q,
                              excess_change_counter_q,
                              state_motion_count_q};
  wire [31:0] rd_mux_w =
    hit_ctrl_w  ? {31'h0, screw_check_ignore_q} :
    hit_fault_w ? {16'h0, fault_word_q} :
    hit_state_w ? state_word_w :
    hit_stat_w  ? {29'h0, irq_stat_q} :
    hit_mask_w  ? {29'h0, irq_mask_q} :
    hit_pos_w   ? {delta_old_q, state_position_saved_q} : 32'h0;

  // Phase register: updated after every analysed comparison
  // A soft reset forgets the level, so a sensor resting high shows a
  // transition on the first pass, which only restarts the count
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sensor_phase_last_q <= 1'b0;
    end else if (soft_reset_w) begin
      sensor_phase_last_q <= 1'b0;
    end else if (analyse_w) begin
      sensor_phase_last_q <= sample_w;
    end
  end

  // Per-state count, saved position and previous delta
  // A transition only restarts the count; the saved position stays, so the
  // first delta of a new state spans the transition pass as well
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_motion_count_q <= 16'sh0000;
      state_position_saved_q <= 16'h0000;
      delta_old_q <= 16'sh0000;
    end else if (soft_reset_w) begin
      state_motion_count_q <= 16'sh0000;
      state_position_saved_q <= 16'h0000;
      delta_old_q <= 16'sh0000;
    end else if (analyse_w && transition_w) begin
      state_motion_count_q <= 16'sh0000;
    end else if (steady_w && !excess_trip_w) begin
      state_motion_count_q <= count_sum_w;
      state_position_saved_q <= focus_position_now_in;
      if (!delta_big_w) begin
        delta_old_q <= delta_new_w;
      end
    end
  end

  // Excess change flag and counter
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      excess_change_flag_q <= 1'b0;
      excess_change_counter_q <= 4'h0;
    end else if (soft_reset_w) begin
      excess_change_flag_q <= 1'b0;
      excess_change_counter_q <= 4'h0;
    end else if (steady_w) begin
      excess_change_flag_q <= delta_big_w;
      // Once at the limit the count stays there and cannot wrap to trip again
      if (delta_big_w && !excess_trip_w && !excess_full_w) begin
        excess_change_counter_q <= excess_next_w;
      end else if (excess_trip_w) begin
        excess_change_counter_q <= sstm_pkg::EXCESS_MAX;  // Holds at limit
      end
    end
  end

  // Fault word, second chance, shutdown and refusal
  // Fault bits only accumulate; the restart bit cannot release a drive
  // whose position commands are refused
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fault_word_q <= 16'h0000;
      second_chance_flag_q <= 1'b0;
      shutdown_q <= 1'b0;
      refuse_q <= 1'b0;
    end else if (soft_reset_w) begin
      fault_word_q <= 16'h0000;
      second_chance_flag_q <= 1'b0;
      shutdown_q <= 1'b0;
      refuse_q <= 1'b0;
    end else if (trip_screw_w) begin
      fault_word_q <= fault_word_q | sstm_pkg::FAULT_SCREW_PAT;
      second_chance_flag_q <= 1'b1;
      shutdown_q <= 1'b1;
      refuse_q <= refuse_q | second_chance_flag_q;
    end else if (trip_excess_w) begin
      fault_word_q <= fault_word_q | sstm_pkg::FAULT_EXCESS_PAT;
      shutdown_q <= 1'b1;
    end else if (restart_w && !refuse_q) begin
      shutdown_q <= 1'b0;  // Refusal keeps the drive stopped
    end
  end

  // Control register and interrupt mask
  // Every control write loads the ignore bit from pwdata bit 0, soft reset writes included
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      screw_check_ignore_q <= 1'b0;
      irq_mask_q <= '0;
    end else begin
      if (wr_ctrl_w) begin
        screw_check_ignore_q <= pwdata[sstm_pkg::CTRL_IGNORE_BIT];
      end
      if (wr_w && hit_mask_w) begin
        irq_mask_q <= pwdata[EV_W-1:0];
      end
    end
  end

  // Sticky events: a new event wins over a write-one clear
  // Soft reset leaves them alone, so software still sees what happened
  // before it reset the tracking state
  wire [EV_W-1:0] ev_w = {trip_excess_w, set_flag_w, trip_screw_w};
  wire [EV_W-1:0] clr_w = (wr_w && hit_stat_w) ? pwdata[EV_W-1:0] : '0;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~clr_w) | ev_w;
    end
  end

  // APB answer: ready one cycle into the access phase
  // Every access gets exactly one wait state, and the answer lasts one
  // cycle, so back-to-back transfers cannot be answered twice
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= access_w && !pready_q;
      pslverr_q <= access_w && !pready_q && !mapped_w;
      if (access_w && !pready_q) begin
        prdata_q <= pwrite ? 32'h0 : rd_mux_w;
      end
    end
  end

  // Registered outputs
  // The interrupt trails the status by one clock so that it leaves a flop
  logic irq_q;
  logic pass_q;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_q <= 1'b0;
      pass_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
      pass_q <= pass_w;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign drive_shutdown_out = shutdown_q;
  assign focus_cmd_refuse_out = refuse_q;
  assign pass_strobe_out = pass_q;
  assign irq_out = irq_q;
endmodule
`default_nettype wire

/* src/sstm_pass_timer.sv */
/*
  Periodic pass strobe generator for the tracking monitor.
  Assumes one free running clock; emits a one-cycle strobe per period.
*/
`timescale 1ns/1ps
`default_nettype none
module sstm_pass_timer #(
  parameter int PERIOD = 22222  // Clock cycles between strobes
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic restart_in,  // Realign the period, e.g. on soft reset
  output logic pass_out         // One-cycle strobe
);
  logic [31:0] cnt_q;           // Cycles since last strobe
  wire last_w = (cnt_q == 32'(PERIOD - 1)); // End of period

  // Count the period and pulse at its end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_q <= 32'h0;
      pass_out <= 1'b0;
    end else begin
      cnt_q <= (last_w || restart_in) ? 32'h0 : cnt_q + 32'h1;
      pass_out <= last_w && !restart_in;
    end
  end
endmodule
`default_nettype wire

/* src/sstm_pkg.sv */
/*
  Package for the second screw tracking monitor: register map, field
  positions, fault patterns, limits and pass timing.
  Assumes a 40 MHz system clock and 16-bit focus position words.
*/
package sstm_pkg;
  // Register byte offsets on APB
  localparam logic [7:0] ADDR_CTRL = 8'h00;     // Control: ignore, soft reset, restart
  localparam logic [7:0] ADDR_FAULT = 8'h04;    // Fault word, read only
  localparam logic [7:0] ADDR_STATE = 8'h08;    // Tracking state readout
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C; // Sticky events, write one to clear
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10; // Interrupt enables
  localparam logic [7:0] ADDR_POS = 8'h14;      // Saved position and last delta

  // Control bit positions
  localparam int CTRL_IGNORE_BIT = 0;  // Screw check ignore, level
  localparam int CTRL_SOFTRST_BIT = 1; // Soft reset command, self clearing
  localparam int CTRL_RESTART_BIT = 2; // Release drive shutdown, self clearing

  // State readout field positions
  localparam int ST_COUNT_LSB = 0;     // state_motion_count [15:0]
  localparam int ST_EXCNT_LSB = 16;    // excess_change_counter [19:16]
  localparam int ST_FLAG_BIT = 20;     // excess_change_flag
  localparam int ST_CHANCE_BIT = 21;   // second_chance_flag
  localparam int ST_SHUT_BIT = 22;     // drive shutdown level
  localparam int ST_REFUSE_BIT = 23;   // focus commands refused
  localparam int ST_PHASE_BIT = 24;    // sensor_phase_last

  // Interrupt event bits
  localparam int EV_SCREW = 0;         // Tracking tolerance exceeded
  localparam int EV_EXCESS = 1;        // Excess change flag raised
  localparam int EV_OVERFLOW = 2;      // Excess change counter reached limit
  localparam int EV_WIDTH = 3;

  // Fault word patterns
  localparam logic [15:0] FAULT_SCREW_PAT = 16'h8200;  // Second screw + drive fault
  localparam logic [15:0] FAULT_EXCESS_PAT = 16'h0A00; // Drive fault + emergency stop

  // Sensor bit inside the discretes byte
  localparam logic [7:0] SENSOR_MASK = 8'h20;

  // Tracking limits in position counts and events
  localparam logic signed [15:0] TRACK_TOL = 16'sh0032;   // 50 counts
  localparam logic signed [15:0] DELTA_LIMIT = 16'sh000C; // 12 counts
  localparam logic [3:0] EXCESS_MAX = 4'hA;                // 10 events

  // Pass timing
  localparam int CLK_HZ = 40000000;
  localparam int PASS_HZ = 1800;
  localparam int PASS_CYCLES = CLK_HZ / PASS_HZ;  // Rounded down, 22222
endpackage

/* testbench/second_screw_tracking_monitor_test.sv */
/*
  Bench for the tracking monitor: APB tasks, passes fed through the far
  side model, one task per scenario. Assumes the checker is bound in.
*/
`timescale 1ns/1ps
`default_nettype none
module second_screw_tracking_monitor_test;
  localparam int P = 40; // Short pass period
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, shut, refuse, strobe, irq;
  logic level = 1'b0;
  logic [15:0] pos = 16'h0;
  logic [7:0] disc;
  logic [15:0] fpos;
  int errors = 0;
  int comparisons = 0;
  sstm_monitor #(.PASS_PERIOD(P)) i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .discretes_in(disc),
    .focus_position_now_in(fpos), .drive_shutdown_out(shut),
    .focus_cmd_refuse_out(refuse), .pass_strobe_out(strobe), .irq_out(irq));
  sstm_far_side i_far (.clk_in(clk_in), .level_in(level), .pos_in(pos),
    .discretes_out(disc), .position_out(fpos));
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe = 1'b0);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  // Present a sample and wait for the pass that takes it
  task automatic pass(input logic [15:0] p, input logic l);
    int n;
    n = 0;
    pos <= p;
    level <= l;
    do begin
      @(posedge clk_in);
      n++;
    end while (strobe !== 1'b1 && n < 3 * P);
    if (n == 3 * P) errors++;
  endtask
  task automatic t_reset;
    rd(sstm_pkg::ADDR_STATE, 32'h0);
    rd(sstm_pkg::ADDR_IRQ_MASK, 32'h0);
    rd(8'h40, 32'h0, 1'b1);
    wr(sstm_pkg::ADDR_IRQ_MASK, 32'h7);
    $display("test reset done");
  endtask
  task automatic t_track;
    for (int k = 0; k <= 5; k++) pass(16'(10 * k), 1'b0);
    rd(sstm_pkg::ADDR_STATE, 32'h32);
    pass(16'h3C, 1'b0);
    rd(sstm_pkg::ADDR_STATE, 32'h0060003C);
    rd(sstm_pkg::ADDR_FAULT, 32'h8200);
    pass(16'h3C, 1'b0);
    chk({30'h0, refuse, shut}, 32'h1);
    pass(16'h3C, 1'b1);
    rd(sstm_pkg::ADDR_STATE, 32'h01600000);
    rd(sstm_pkg::ADDR_IRQ_STAT, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(sstm_pkg::ADDR_IRQ_STAT, 32'h1);
    wr(sstm_pkg::ADDR_CTRL, 32'h4);
    rd(sstm_pkg::ADDR_STATE, 32'h01200000);
    chk({31'h0, irq}, 32'h0);
    $display("test track done");
  endtask
  task automatic t_second;
    for (int k = 1; k <= 6; k++) pass(16'(60 + 10 * k), 1'b1);
    chk({30'h0, refuse, shut}, 32'h3);
    wr(sstm_pkg::ADDR_CTRL, 32'h4);
    rd(sstm_pkg::ADDR_STATE, 32'h01E0003C);
    pass(16'h0, 1'b0);
    $display("test second done");
  endtask
  task automatic t_soft;
    wr(sstm_pkg::ADDR_CTRL, 32'h2);
    rd(sstm_pkg::ADDR_STATE, 32'h0);
    rd(sstm_pkg::ADDR_FAULT, 32'h0);
    wr(sstm_pkg::ADDR_IRQ_STAT, 32'h7);
    wr(sstm_pkg::ADDR_CTRL, 32'h1);
    pass(16'hC8, 1'b1);
    rd(sstm_pkg::ADDR_STATE, 32'h0);
    rd(sstm_pkg::ADDR_CTRL, 32'h1);
    pass(16'h0, 1'b0);
    wr(sstm_pkg::ADDR_CTRL, 32'h0);
    $display("test soft done");
  endtask
  task automatic t_excess;
    pass(16'h0, 1'b0);
    pass(16'hC, 1'b0);
    pass(16'h19, 1'b0);
    rd(sstm_pkg::ADDR_STATE, 32'h00110018);
    rd(sstm_pkg::ADDR_POS, 32'h000C0019);
    pass(16'h19, 1'b0);
    for (int k = 1; k <= 10; k++) pass(16'(25 - 13 * k), 1'b0);
    rd(sstm_pkg::ADDR_STATE, 32'h005A0018);
    rd(sstm_pkg::ADDR_FAULT, 32'h0A00);
    rd(sstm_pkg::ADDR_IRQ_STAT, 32'h6);
    $display("test excess done");
  endtask
  task automatic final_report;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run of 32 passes of 40 cycles, under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    final_report;
  end
  initial begin
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'b1;
    t_reset;
    t_track;
    t_second;
    t_soft;
    t_excess;
    final_report;
  end
endmodule
`default_nettype wire

/* testbench/sstm_far_side.sv */
/*
  Far side model: second screw sensor discrete and focus position readout.
  Assumes the bench sets the level and position between passes.
*/
`timescale 1ns/1ps
`default_nettype none
module sstm_far_side (
  input wire logic clk_in,
  input wire logic level_in,        // Wanted sensor level
  input wire logic [15:0] pos_in,   // Wanted focus position
  output logic [7:0] discretes_out, // Discretes byte
  output logic [15:0] position_out  // Position readout
);
  logic [6:0] noise_q = 7'h55; // Other discretes bits churn every cycle
  // Square wave level comes from the bench, either start level
  always_ff @(posedge clk_in) begin
    noise_q <= noise_q + 7'h01;
    position_out <= pos_in;
    discretes_out <= {noise_q[6:5], level_in, noise_q[4:0]}; // Sensor on bit 5
  end
endmodule
`default_nettype wire

/* testbench/sstm_monitor_asserts.sv */
/*
  Port checker for the tracking monitor, bound into sstm_monitor.
  Assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module sstm_monitor_asserts #(
  parameter int PASS_PERIOD = 20
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic drive_shutdown_out,
  input wire logic focus_cmd_refuse_out,
  input wire logic pass_strobe_out,
  input wire logic irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  int gap_q; // Cycles since the last pass strobe
  logic seen_q; // A strobe has been seen since reset
  wire any_wr = psel && penable && pready && pwrite;
  wire ctrl_wr = any_wr && paddr == sstm_pkg::ADDR_CTRL;
  wire soft_wr = ctrl_wr && pwdata[sstm_pkg::CTRL_SOFTRST_BIT];
  wire restart_ok = ctrl_wr && pwdata[sstm_pkg::CTRL_RESTART_BIT] && !focus_cmd_refuse_out;
  wire release_wr = soft_wr || restart_ok; // Writes that may lift a shutdown
  wire mapped = paddr <= sstm_pkg::ADDR_POS && paddr[1:0] == 2'h0;
  // Measure the spacing of pass strobes
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gap_q <= 0;
      seen_q <= 1'b0;
    end else if (pass_strobe_out) begin
      gap_q <= 0;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 1;
    end
  end
  property p_pass_gap;
    pass_strobe_out && seen_q |-> gap_q >= PASS_PERIOD - 1;
  endproperty
  a_pass_gap: assert property (p_pass_gap) else $error("pass strobes too close");
  property p_shut_rise;
    $rose(drive_shutdown_out) |-> pass_strobe_out;
  endproperty
  a_shut_rise: assert property (p_shut_rise) else $error("shutdown off pass");
  property p_refuse_rise;
    $rose(focus_cmd_refuse_out) |-> drive_shutdown_out && pass_strobe_out;
  endproperty
  a_refuse_rise: assert property (p_refuse_rise) else $error("refuse off pass");
  property p_refuse_shut;
    focus_cmd_refuse_out |-> drive_shutdown_out;
  endproperty
  a_refuse_shut: assert property (p_refuse_shut) else $error("refuse without stop");
  property p_refuse_fall;
    $fell(focus_cmd_refuse_out) |-> $past(soft_wr);
  endproperty
  a_refuse_fall: assert property (p_refuse_fall) else $error("refuse lifted");
  property p_shut_fall;
    $fell(drive_shutdown_out) |-> $past(release_wr);
  endproperty
  a_shut_fall: assert property (p_shut_fall) else $error("shutdown lifted");
  property p_irq_rise;
    $rose(irq_out) |-> $past(pass_strobe_out) || $past(any_wr, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("stray interrupt");
  property p_ready_wait;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("bad wait state");
  property p_err_map;
    pready |-> pslverr == !mapped;
  endproperty
  a_err_map: assert property (p_err_map) else $error("bad error response");
  c_shut: cover property ($rose(drive_shutdown_out));
  c_refuse: cover property ($rose(focus_cmd_refuse_out));
  c_err: cover property (pready && pslverr);
endmodule
bind sstm_monitor sstm_monitor_asserts #(.PASS_PERIOD(PASS_PERIOD)) u_asserts (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .drive_shutdown_out(drive_shutdown_out), .focus_cmd_refuse_out(focus_cmd_refuse_out),
  .pass_strobe_out(pass_strobe_out), .irq_out(irq_out));
`default_nettype wire
